// ---- src/ipl_pkg.sv ----
// Purpose: Shared constants and carrier types for the interrupt poll and priority logic.
// Assumes: One clock, APB register access, 24 vector slots in ascending vector order.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package ipl_pkg;

  // Register byte offsets.
  localparam logic [7:0] IPL_OFS_TCTRL  = 8'h00;
  localparam logic [7:0] IPL_OFS_EDGE   = 8'h04;
  localparam logic [7:0] IPL_OFS_STAT_A = 8'h08;
  localparam logic [7:0] IPL_OFS_STAT_B = 8'h0C;
  localparam logic [7:0] IPL_OFS_ENABLE = 8'h10;
  localparam logic [7:0] IPL_OFS_PRIO0  = 8'h14;
  localparam logic [7:0] IPL_OFS_PRIO1  = 8'h18;
  localparam logic [7:0] IPL_OFS_ACTIVE = 8'h1C;
  localparam logic [7:0] IPL_OFS_STACK  = 8'h20;

  // Values after reset, and the stack pointer step.
  localparam logic [7:0]  IPL_RST_BYTE  = 8'h00;
  localparam logic [23:0] IPL_RST_EN    = 24'h000000;
  localparam logic [5:0]  IPL_RST_PRIO  = 6'h00;
  localparam logic [7:0]  IPL_RST_SP    = 8'h07;
  localparam logic [7:0]  IPL_SP_STEP   = 8'h02;

  // Bit positions in timer_and_ext_irq_control.
  localparam int IPL_TC_A_TYPE = 0;
  localparam int IPL_TC_A_FLAG = 1;
  localparam int IPL_TC_B_TYPE = 2;
  localparam int IPL_TC_B_FLAG = 3;
  localparam int IPL_TC_A_RUN  = 4;
  localparam int IPL_TC_A_OVF  = 5;
  localparam int IPL_TC_B_RUN  = 6;
  localparam int IPL_TC_B_OVF  = 7;

  // Bit positions in ext_irq_edge_select.
  localparam int IPL_ES_A_FALL  = 0;
  localparam int IPL_ES_A_RISE  = 1;
  localparam int IPL_ES_B_FALL  = 2;
  localparam int IPL_ES_B_RISE  = 3;
  localparam int IPL_ES_XA_FALL = 4;
  localparam int IPL_ES_XA_RISE = 5;
  localparam int IPL_ES_XB_FALL = 6;
  localparam int IPL_ES_XB_RISE = 7;

  // Bit positions of the extra edge flags in latched_request_status_b.
  localparam int IPL_SB_XA = 0;
  localparam int IPL_SB_XB = 1;

  // Source slots, ascending vector address.
  localparam int IPL_NUM_SRC  = 24;
  localparam int IPL_NUM_GRP  = 6;
  localparam int IPL_SRC_EXTA = 0;
  localparam int IPL_SRC_TMRA = 1;
  localparam int IPL_SRC_EXTB = 2;
  localparam int IPL_SRC_TMRB = 3;
  localparam int IPL_SRC_UART = 4;
  localparam int IPL_SRC_GAP  = 14;
  localparam logic [15:0] IPL_VEC_BASE = 16'h0003;
  localparam logic [15:0] IPL_VEC_STEP = 16'h0008;
  localparam logic [15:0] IPL_VEC_SKIP = 16'h0010;

  // Sequencer states, Gray coded.
  typedef enum logic [0:0] {
    IPL_IDLE = 1'b0,
    IPL_CALL = 1'b1
  } ipl_state_t;

  // Status of the instruction sequencer; the instruction flags are sampled on the machine-cycle strobe.
  typedef struct packed {
    logic mc_strobe;
    logic last_of_multi;
    logic insn_return_from_interrupt;
    logic insn_wr_en_prio;
    logic call_taken;
    logic return_from_interrupt_exec;
  } ipl_core_in_t;

  // Hardware call request towards the sequencer.
  typedef struct packed {
    logic        req;
    logic        push_status;
    logic [15:0] vector;
    logic [1:0]  level;
  } ipl_call_t;

endpackage : ipl_pkg

// ---- src/ipl_ctrl.sv ----
// Purpose: Interrupt sampling, polling, priority arbitration and hardware call issue.
// Assumes: All inputs are synchronous to pclk; the core pulses mc_strobe at the sampling step.
// Notes:   APB slave with no wait states; the core owns the pushes and pops on the stack.
//
// Our own choices: the register offsets and register access over APB.
module ipl_ctrl
  import ipl_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire ipl_core_in_t core_i,
  output ipl_call_t         call_o,
  output logic [7:0]        stack_ptr,
  input  wire logic         ext_a_pin,
  input  wire logic         ext_b_pin,
  input  wire logic         extra_a_pin,
  input  wire logic         extra_b_pin,
  input  wire logic         timer_a_ovf,
  input  wire logic         timer_b_ovf,
  input  wire logic         uart_req,
  input  wire logic [7:0]   latch_set_a,
  input  wire logic [7:0]   latch_set_b,
  output logic              timer_a_run,
  output logic              timer_b_run
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    ipl_state_t  state;
    logic [7:0]  tctrl;
    logic [7:0]  edge_sel;
    logic [7:0]  stat_a;
    logic [7:0]  stat_b;
    logic [23:0] enable;
    logic [5:0]  prio0;
    logic [5:0]  prio1;
    logic [3:0]  active;
    logic [23:0] sampled;
    logic [3:0]  pin_prev;
    logic        wr_seen;
    logic [15:0] vector;
    logic [1:0]  level;
    logic [4:0]  src;
    logic [7:0]  sp;
    logic [31:0] rdata;
    logic        err;
  } ipl_st_t;

  ipl_st_t st_q;
  ipl_st_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Vector address of a source slot; slots from the gap on sit 16 bytes higher.
  function automatic logic [15:0] ipl_vec(input int i);
    logic [15:0] v;
    v = IPL_VEC_BASE + IPL_VEC_STEP * 16'(i);
    if (i >= IPL_SRC_GAP) begin
      v = v + IPL_VEC_SKIP;
    end
    return v;
  endfunction : ipl_vec

  // Priority level of a source slot from its group bits.
  function automatic logic [1:0] ipl_lvl(input int i, input logic [5:0] p0,
                                         input logic [5:0] p1);
    int g;
    g = i % IPL_NUM_GRP;
    return {p1[g], p0[g]};
  endfunction : ipl_lvl

  // Flag of a main external input from its mode bits.
  function automatic logic ipl_ext_flag(input logic flag, input logic typ, input logic rs,
                                        input logic fs, input logic pin, input logic prev);
    logic f;
    if (!typ) begin
      f = (rs ^ fs) ? (rs ? pin : !pin) : 1'b0;
    end else begin
      f = flag | (rs & pin & !prev) | (fs & !pin & prev);
    end
    return f;
  endfunction : ipl_ext_flag

  // Edge detector of an extra input.
  function automatic logic ipl_edge(input logic rs, input logic fs, input logic pin,
                                    input logic prev);
    return (rs & pin & !prev) | (fs & !pin & prev);
  endfunction : ipl_edge

  ////////////////////////////////////////////////////////////////////////////
  // Request map and APB decode.

  logic [23:0] raw_req;
  logic        apb_setup;
  logic        apb_wr;
  logic        mapped;

  // Gathers the request of every slot; empty slots stay low.
  always_comb begin
    raw_req               = 24'h000000;
    raw_req[IPL_SRC_EXTA] = st_q.tctrl[IPL_TC_A_FLAG];
    raw_req[IPL_SRC_TMRA] = st_q.tctrl[IPL_TC_A_OVF];
    raw_req[IPL_SRC_EXTB] = st_q.tctrl[IPL_TC_B_FLAG];
    raw_req[IPL_SRC_TMRB] = st_q.tctrl[IPL_TC_B_OVF];
    raw_req[IPL_SRC_UART] = uart_req;
    raw_req[5]            = st_q.stat_a[6];
    raw_req[7]            = st_q.stat_b[IPL_SB_XA];
    raw_req[8]            = st_q.stat_a[5];
    raw_req[9]            = st_q.stat_b[IPL_SB_XB];
    raw_req[10]           = st_q.stat_a[4];
    raw_req[11]           = st_q.stat_a[3];
    raw_req[14]           = st_q.stat_a[2];
    raw_req[15]           = st_q.stat_b[7];
    raw_req[16]           = st_q.stat_a[1];
    raw_req[17]           = st_q.stat_a[0];
    raw_req[22]           = st_q.stat_a[7];
    raw_req[23]           = st_q.stat_b[6];
  end

  // Setup and access phase qualifiers.
  assign apb_setup = psel & !penable;
  assign apb_wr    = psel & penable & pwrite & !st_q.err;
  assign mapped    = (paddr[1:0] == 2'b00) && (paddr <= IPL_OFS_STACK);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic        found;
    logic [1:0]  best_lvl;
    logic [4:0]  best_src;
    logic [1:0]  li;
    logic        inhibit;
    logic [1:0]  top;
    st_d     = st_q;
    found    = 1'b0;
    best_lvl = 2'b00;
    best_src = 5'h00;
    li       = 2'b00;
    inhibit  = 1'b0;
    top      = 2'b00;

    // Read data and error are captured in the setup phase.
    if (apb_setup) begin
      st_d.err   = !mapped;
      st_d.rdata = 32'h00000000;
      unique case (paddr)
        IPL_OFS_TCTRL:  st_d.rdata[7:0]  = st_q.tctrl;
        IPL_OFS_EDGE:   st_d.rdata[7:0]  = st_q.edge_sel;
        IPL_OFS_STAT_A: st_d.rdata[7:0]  = st_q.stat_a;
        IPL_OFS_STAT_B: st_d.rdata[7:0]  = st_q.stat_b;
        IPL_OFS_ENABLE: st_d.rdata[23:0] = st_q.enable;
        IPL_OFS_PRIO0:  st_d.rdata[5:0]  = st_q.prio0;
        IPL_OFS_PRIO1:  st_d.rdata[5:0]  = st_q.prio1;
        IPL_OFS_ACTIVE: st_d.rdata[3:0]  = st_q.active;
        IPL_OFS_STACK:  st_d.rdata[7:0]  = st_q.sp;
        default:        st_d.rdata       = 32'h00000000;
      endcase
    end

    // Software writes take effect in the access phase.
    if (apb_wr) begin
      unique case (paddr)
        IPL_OFS_TCTRL:  st_d.tctrl    = pwdata[7:0];
        IPL_OFS_EDGE:   st_d.edge_sel = pwdata[7:0];
        IPL_OFS_STAT_A: st_d.stat_a   = pwdata[7:0];
        IPL_OFS_STAT_B: st_d.stat_b   = pwdata[7:0];
        IPL_OFS_ENABLE: st_d.enable   = pwdata[23:0];
        IPL_OFS_PRIO0:  st_d.prio0    = pwdata[5:0];
        IPL_OFS_PRIO1:  st_d.prio1    = pwdata[5:0];
        default:        st_d.sp       = st_q.sp;
      endcase
      if (paddr == IPL_OFS_ENABLE || paddr == IPL_OFS_PRIO0 || paddr == IPL_OFS_PRIO1) begin
        st_d.wr_seen = 1'b1;
      end
    end

    // Entry into the routine clears timer flags and edge-mode input flags only.
    if (st_q.state == IPL_CALL && core_i.call_taken) begin
      st_d.state = IPL_IDLE;
      st_d.active[st_q.level] = 1'b1;
      st_d.sp = st_q.sp + IPL_SP_STEP;
      unique case (int'(st_q.src))
        IPL_SRC_EXTA: st_d.tctrl[IPL_TC_A_FLAG] = 1'b0;
        IPL_SRC_TMRA: st_d.tctrl[IPL_TC_A_OVF]  = 1'b0;
        IPL_SRC_EXTB: st_d.tctrl[IPL_TC_B_FLAG] = 1'b0;
        IPL_SRC_TMRB: st_d.tctrl[IPL_TC_B_OVF]  = 1'b0;
        default:      st_d.src = st_q.src;
      endcase
    end

    // Return releases the highest active level; lower levels stay set.
    if (core_i.return_from_interrupt_exec) begin
      for (int l = 0; l < 4; l++) begin
        if (st_q.active[l]) begin
          top = 2'(l);
        end
      end
      st_d.active[top] = 1'b0;
      st_d.sp = st_d.sp - IPL_SP_STEP;
    end

    // Hardware sets are applied last so that they win over any clear.
    st_d.tctrl[IPL_TC_A_FLAG] = ipl_ext_flag(st_d.tctrl[IPL_TC_A_FLAG],
                                             st_q.tctrl[IPL_TC_A_TYPE],
                                             st_q.edge_sel[IPL_ES_A_RISE],
                                             st_q.edge_sel[IPL_ES_A_FALL],
                                             ext_a_pin, st_q.pin_prev[0]);
    st_d.tctrl[IPL_TC_B_FLAG] = ipl_ext_flag(st_d.tctrl[IPL_TC_B_FLAG],
                                             st_q.tctrl[IPL_TC_B_TYPE],
                                             st_q.edge_sel[IPL_ES_B_RISE],
                                             st_q.edge_sel[IPL_ES_B_FALL],
                                             ext_b_pin, st_q.pin_prev[1]);
    st_d.tctrl[IPL_TC_A_OVF] = st_d.tctrl[IPL_TC_A_OVF] | timer_a_ovf;
    st_d.tctrl[IPL_TC_B_OVF] = st_d.tctrl[IPL_TC_B_OVF] | timer_b_ovf;
    st_d.stat_a = st_d.stat_a | latch_set_a;
    st_d.stat_b = st_d.stat_b | latch_set_b;
    st_d.stat_b[IPL_SB_XA] = st_d.stat_b[IPL_SB_XA]
                           | ipl_edge(st_q.edge_sel[IPL_ES_XA_RISE],
                                      st_q.edge_sel[IPL_ES_XA_FALL],
                                      extra_a_pin, st_q.pin_prev[2]);
    st_d.stat_b[IPL_SB_XB] = st_d.stat_b[IPL_SB_XB]
                           | ipl_edge(st_q.edge_sel[IPL_ES_XB_RISE],
                                      st_q.edge_sel[IPL_ES_XB_FALL],
                                      extra_b_pin, st_q.pin_prev[3]);
    st_d.pin_prev = {extra_b_pin, extra_a_pin, ext_b_pin, ext_a_pin};

    // Machine-cycle strobe: poll the previous samples, then take new ones.
    if (core_i.mc_strobe) begin
      inhibit = core_i.last_of_multi | core_i.insn_return_from_interrupt
              | core_i.insn_wr_en_prio | st_q.wr_seen;
      for (int i = 0; i < IPL_NUM_SRC; i++) begin
        li = ipl_lvl(i, st_q.prio0, st_q.prio1);
        if (st_q.sampled[i] && ((st_q.active >> li) == 4'h0)) begin
          if (!found || li > best_lvl) begin
            found    = 1'b1;
            best_lvl = li;
            best_src = 5'(i);
          end
        end
      end
      if (found && !inhibit && st_q.state == IPL_IDLE) begin
        st_d.state  = IPL_CALL;
        st_d.level  = best_lvl;
        st_d.src    = best_src;
        st_d.vector = ipl_vec(int'(best_src));
      end
      // Samples are rebuilt on every strobe, so a blocked direct request is lost.
      st_d.sampled = raw_req & st_q.enable;
      st_d.wr_seen = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{state: IPL_IDLE, tctrl: IPL_RST_BYTE, edge_sel: IPL_RST_BYTE,
                stat_a: IPL_RST_BYTE, stat_b: IPL_RST_BYTE, enable: IPL_RST_EN,
                prio0: IPL_RST_PRIO, prio1: IPL_RST_PRIO, active: 4'h0,
                sampled: 24'h000000, pin_prev: 4'h0, wr_seen: 1'b0,
                vector: 16'h0000, level: 2'b00, src: 5'h00, sp: IPL_RST_SP,
                rdata: 32'h00000000, err: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // APB answer one cycle after setup; error flags unmapped addresses.
  assign pready  = psel & penable;
  assign pslverr = psel & penable & st_q.err;
  assign prdata  = st_q.rdata;

  // Call request holds until the core takes it; the status word is never pushed.
  assign call_o.req         = (st_q.state == IPL_CALL);
  assign call_o.push_status = 1'b0;
  assign call_o.vector      = st_q.vector;
  assign call_o.level       = st_q.level;
  assign stack_ptr          = st_q.sp;
  assign timer_a_run        = st_q.tctrl[IPL_TC_A_RUN];
  assign timer_b_run        = st_q.tctrl[IPL_TC_B_RUN];

endmodule : ipl_ctrl

// ---- verification/ipl_ctrl_checker.sv ----
// Purpose: Port-level assertions for the interrupt poll and priority block.
// Assumes: One pclk domain; presetn is active low and asynchronous.
// Notes:   Bound into every ipl_ctrl instance below the module.
module ipl_ctrl_checker
  import ipl_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire ipl_core_in_t core_i,
  input wire ipl_call_t    call_o,
  input wire logic [7:0]   stack_ptr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // A call may only start on the poll that follows a strobe, and never on an inhibited poll.
  call_sample_a: assert property ($rose(call_o.req) |-> $past(core_i.mc_strobe))
    else $error("call raised without a sampling strobe");
  multi_hold_a: assert property (core_i.mc_strobe && core_i.last_of_multi |=> !$rose(call_o.req))
    else $error("call raised on last cycle of a long instruction");
  return_from_interrupt_hold_a: assert property (core_i.mc_strobe && (core_i.insn_return_from_interrupt || core_i.insn_wr_en_prio)
    |=> !$rose(call_o.req))
    else $error("call raised during return or enable write");

  ////////////////////////////////////////////////////////////////////////////
  // The call itself: no status push, a fixed vector, held until taken, then dropped.
  no_status_push_a: assert property (call_o.req |-> !call_o.push_status)
    else $error("call pushes the status word");
  vector_form_a: assert property (call_o.req |-> call_o.vector[2:0] == 3'h3 && call_o.vector < 16'h00D0)
    else $error("call vector outside the vector table");
  call_stands_a: assert property (call_o.req && !core_i.call_taken
    |=> call_o.req && $stable(call_o.vector) && $stable(call_o.level))
    else $error("call request changed before it was taken");
  call_ends_a: assert property (call_o.req && core_i.call_taken |=> !call_o.req)
    else $error("call request stayed after it was taken");

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer moves by two on each call and each return.
  push_two_a: assert property (call_o.req && core_i.call_taken && !core_i.return_from_interrupt_exec
    |=> stack_ptr == $past(stack_ptr) + 8'h02)
    else $error("stack pointer not raised by two on call");
  pop_two_a: assert property (core_i.return_from_interrupt_exec && !(call_o.req && core_i.call_taken)
    |=> stack_ptr == $past(stack_ptr) - 8'h02)
    else $error("stack pointer not lowered by two on return");
endmodule : ipl_ctrl_checker

bind ipl_ctrl ipl_ctrl_checker ipl_ctrl_checker_inst (
  .pclk      (pclk),
  .presetn   (presetn),
  .core_i    (core_i),
  .call_o    (call_o),
  .stack_ptr (stack_ptr)
);

// ---- verification/ipl_core_model.sv ----
// Purpose: Behavioural instruction sequencer facing the interrupt block.
// Assumes: A machine cycle of MC_LEN clocks with one strobe in each.
// Notes:   Acknowledges calls promptly or, with slow set, four cycles late.
module ipl_core_model
  import ipl_pkg::*;
#(
  parameter int MC_LEN = 12
)
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire ipl_call_t  call_i,
  input  wire logic       slow,
  input  wire logic [2:0] inhibit,
  input  wire logic       return_from_interrupt_cmd,
  output ipl_core_in_t    core_o
);
  int phase_q;
  int wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // Machine-cycle strobe, instruction status, call acknowledge and return pulses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 0;
      wait_q  <= 0;
      core_o  <= '0;
    end else begin
      phase_q <= (phase_q == MC_LEN - 1) ? 0 : phase_q + 1;
      core_o.mc_strobe <= (phase_q == MC_LEN - 2);
      {core_o.last_of_multi, core_o.insn_return_from_interrupt, core_o.insn_wr_en_prio} <= inhibit;
      core_o.return_from_interrupt_exec <= return_from_interrupt_cmd;
      wait_q <= (call_i.req && !core_o.call_taken) ? wait_q + 1 : 0;
      core_o.call_taken <= call_i.req && !core_o.call_taken && wait_q == (slow ? 4 : 0);
    end
  end
endmodule : ipl_core_model

// ---- verification/tb_ipl_ctrl.sv ----
// Purpose: Self-checking bench for the interrupt poll and priority block.
// Assumes: APB master in this module; sequencer model on the call side.
// Notes:   Request lines that no scenario needs are held low; extra_b_pin follows ext_b with its edges unselected.
module tb_ipl_ctrl
  import ipl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00, set_a = 8'h00, stack_ptr;
  logic [31:0]  pwdata = 32'h0, prdata, rd;
  logic         pready, pslverr, err, run_a, run_b;
  logic         ext_a = 1'b0, ext_b = 1'b0, tmr_b = 1'b0, slow = 1'b0, return_from_interrupt_cmd = 1'b0;
  logic [2:0]   inhibit = 3'h0;
  ipl_core_in_t core;
  ipl_call_t    call;
  int           fails = 0, checks = 0, cyc = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and sequencer model.
  always #25 pclk = ~pclk;

  ipl_ctrl ipl_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_i(core), .call_o(call), .stack_ptr(stack_ptr),
    .ext_a_pin(ext_a), .ext_b_pin(ext_b), .extra_a_pin(ext_b), .extra_b_pin(ext_b),
    .timer_a_ovf(1'b0), .timer_b_ovf(tmr_b), .uart_req(1'b0), .latch_set_a(set_a),
    .latch_set_b(8'h00), .timer_a_run(run_a), .timer_b_run(run_b));

  ipl_core_model ipl_core_model_inst (.pclk(pclk), .presetn(presetn), .call_i(call),
    .slow(slow), .inhibit(inhibit), .return_from_interrupt_cmd(return_from_interrupt_cmd), .core_o(core));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks for comparison, bus cycles, calls and returns.
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) fails++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(what, exp, rd);
  endtask : rdchk

  task automatic serve(input logic [15:0] vec, input logic [7:0] sp);
    int n;
    n = 0;
    while (call.req !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    cmp("latency ok", 32'h1, 32'(n <= 108));
    cmp("vector", {16'h0, vec}, {16'h0, call.vector});
    while (call.req === 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    cmp("stack", {24'h0, sp}, {24'h0, stack_ptr});
  endtask : serve

  task automatic return_from_interrupt(input logic [7:0] sp);
    @(posedge pclk);
    return_from_interrupt_cmd <= 1'b1;
    @(posedge pclk);
    return_from_interrupt_cmd <= 1'b0;
    repeat (3) @(posedge pclk);
    cmp("stack", {24'h0, sp}, {24'h0, stack_ptr});
  endtask : return_from_interrupt

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs;
    rdchk("stack reset", IPL_OFS_STACK, 32'h07);
    apb(1'b1, 8'h40, 32'hFF);
    cmp("slverr", 32'h1, {31'h0, err});
    apb(1'b1, IPL_OFS_TCTRL, 32'h55);
    rdchk("ctrl", IPL_OFS_TCTRL, 32'h55);
    cmp("run bits", 32'h3, {30'h0, run_b, run_a});
  endtask : t_regs

  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, IPL_OFS_TCTRL, m[2] ? 32'h55 : 32'h51);
      apb(1'b1, IPL_OFS_EDGE, {26'h0, 2'(m), 2'(m), 2'h0});
      apb(1'b1, IPL_OFS_STAT_B, 32'h0);
      ext_b <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, IPL_OFS_TCTRL, 32'h0);
      cmp("flag after rise", 32'(m == 2 || m >= 6), {31'h0, rd[3]});
      rdchk("extra after rise", IPL_OFS_STAT_B, 32'(m[1]));
      ext_b <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, IPL_OFS_TCTRL, 32'h0);
      cmp("flag after fall", 32'(m == 1 || m >= 5), {31'h0, rd[3]});
      rdchk("extra after fall", IPL_OFS_STAT_B, 32'(m[1] | m[0]));
    end
  endtask : t_modes

  task automatic t_nest;
    apb(1'b1, IPL_OFS_TCTRL, 32'h55);
    apb(1'b1, IPL_OFS_PRIO0, 32'h38);
    apb(1'b1, IPL_OFS_PRIO1, 32'h08);
    apb(1'b1, IPL_OFS_ENABLE, 32'h0003_0008);
    set_a <= 8'h03;
    @(posedge pclk);
    set_a <= 8'h00;
    serve(16'h0093, 8'h09);
    rdchk("status kept", IPL_OFS_STAT_A, 32'h03);
    rdchk("active", IPL_OFS_ACTIVE, 32'h02);
    repeat (40) @(posedge pclk);
    cmp("same level held", 32'h0, {31'h0, call.req});
    slow  <= 1'b1;
    tmr_b <= 1'b1;
    @(posedge pclk);
    tmr_b <= 1'b0;
    serve(16'h001B, 8'h0B);
    rdchk("timer flag", IPL_OFS_TCTRL, 32'h55);
    rdchk("active", IPL_OFS_ACTIVE, 32'h0A);
    return_from_interrupt(8'h09);
    rdchk("lower kept", IPL_OFS_ACTIVE, 32'h02);
    apb(1'b1, IPL_OFS_STAT_A, 32'h0);
    repeat (24) @(posedge pclk); // Let two strobes flush the stale samples.
    return_from_interrupt(8'h07);
    rdchk("none active", IPL_OFS_ACTIVE, 32'h0);
  endtask : t_nest

  task automatic t_hold;
    apb(1'b1, IPL_OFS_EDGE, 32'h02);
    apb(1'b1, IPL_OFS_ENABLE, 32'h1);
    ext_a <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      inhibit <= 3'(1 << k);
      repeat (40) @(posedge pclk);
      cmp("withheld", 32'h0, {31'h0, call.req});
    end
    inhibit <= 3'h0;
    serve(16'h0003, 8'h09);
    rdchk("edge flag", IPL_OFS_TCTRL, 32'h55);
    return_from_interrupt(8'h07);
  endtask : t_hold

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and cycle ceiling.
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_modes;
    t_nest;
    t_hold;
    stop_test;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test;
    end
  end
endmodule : tb_ipl_ctrl
